// ===== hw/corner_turn.sv
// 8x8 two-dimensional shift array turning serial streams into words and back
//
// Contract
// [RULE_01] Sixty-four cells in eight rows and eight columns share one clock with no extra cells.
// [RULE_02] In row shift mode each cell takes its left neighbour, moving rows right by one.
// [RULE_03] In column shift mode each cell takes the cell above, moving columns down by one.
// [RULE_04] The first eight steps of a cycle are row shifts taking one serial stream per row.
// [RULE_05] The next eight steps are column shifts, one eight-bit word leaving per step.
// [RULE_06] New data enters one edge on the same steps that old data leaves the opposite edge.
// [RULE_07] After eight column steps the mode returns to row shift, old data leaving on the right.
// [RULE_08] The mode comes from a free-running divide-by-eight counter that toggles it every eight; here the counter steps only on advance.
// [RULE_09] The same array converts parallel words back into eight serial streams.
// [RULE_10] The outside merges the bottom-row and right-column outputs, each valid in its phase.
// [RULE_11] After reset the counter starts at zero in row shift mode for the first input block.
`timescale 1ns/100ps

module corner_turn (
   // Clock, reset and enable
   input  wire logic                                  sys_clk,
   input  wire logic                                  reset_n,
   input  wire logic                                  clk_en,
   // Input side: one bit per row, or one word across the columns
   input  wire logic [corner_turn_pkg::ARRAY_DIM-1:0] din,
   input  wire logic                                  in_valid,
   output      logic                                  in_ready,
   // Raw array edges
   output      logic [corner_turn_pkg::ARRAY_DIM-1:0] right_bits,
   output      logic [corner_turn_pkg::ARRAY_DIM-1:0] bottom_bits,
   output      corner_turn_pkg::mode_t                mode,
   // Buffered merged output
   output      corner_turn_pkg::word_t                out_word,
   output      logic                                  out_valid,
   input  wire logic                                  out_ready
);

   corner_turn_pkg::cells_t                  cell_reg;
   corner_turn_pkg::cells_t                  cell_next;
   logic [corner_turn_pkg::CNT_W-1:0]        cnt_reg;
   corner_turn_pkg::mode_t                   mode_reg;
   logic                                     primed_reg;
   corner_turn_pkg::word_t                   out_reg;
   logic                                     out_valid_reg;
   corner_turn_pkg::word_t                   skid_reg;
   logic                                     skid_valid_reg;
   logic                                     in_ready_reg;

   logic                                     advance;
   logic                                     wrap;
   logic                                     push;
   logic                                     out_load;
   logic                                     skid_valid_next;
   corner_turn_pkg::word_t                   leaving;

   function automatic corner_turn_pkg::row_t right_column(input corner_turn_pkg::cells_t c);
      corner_turn_pkg::row_t r;
      r = corner_turn_pkg::ROW_RESET;
      for (int i = 0; i < corner_turn_pkg::ARRAY_DIM; i++) begin
         r[i] = c[i][corner_turn_pkg::ARRAY_DIM-1];
      end
      return r;
   endfunction : right_column

   // The array only steps when a word is offered and the buffer has room
   assign advance  = clk_en & in_valid & in_ready_reg;
   assign wrap     = advance & (cnt_reg == corner_turn_pkg::CNT_LAST);
   // Reset contents leaving during the very first phase are not data
   assign push     = advance & primed_reg;
   assign out_load = ~out_valid_reg | out_ready;
   assign skid_valid_next = ~out_load & (skid_valid_reg | push);

   assign leaving.from_bottom = (mode_reg == corner_turn_pkg::COLUMN_SHIFT_MODE);
   assign leaving.bits        = leaving.from_bottom ?
                                cell_reg[corner_turn_pkg::ARRAY_DIM-1] : right_column(cell_reg);

   // Next array contents, one shift direction per mode
   always_comb begin
      cell_next = cell_reg;
      for (int r = 0; r < corner_turn_pkg::ARRAY_DIM; r++) begin
         if (mode_reg == corner_turn_pkg::ROW_SHIFT_MODE) begin
            cell_next[r] = {cell_reg[r][corner_turn_pkg::ARRAY_DIM-2:0], din[r]}; // RULE_02
         end else if (r == 0) begin
            cell_next[r] = din; // RULE_09
         end else begin
            cell_next[r] = cell_reg[r-1]; // RULE_03
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cell_reg <= {corner_turn_pkg::ARRAY_DIM{corner_turn_pkg::ROW_RESET}};
      end else if (advance) begin
         cell_reg <= cell_next; // RULE_01 RULE_06
      end
   end

   // Phase counter and mode
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg    <= corner_turn_pkg::CNT_RESET; // RULE_11
         mode_reg   <= corner_turn_pkg::ROW_SHIFT_MODE; // RULE_11
         primed_reg <= 1'b0;
      end else if (advance) begin
         cnt_reg <= cnt_reg + corner_turn_pkg::CNT_ONE; // RULE_08
         if (wrap) begin
            primed_reg <= 1'b1;
            case (mode_reg)
               corner_turn_pkg::ROW_SHIFT_MODE:    mode_reg <= corner_turn_pkg::COLUMN_SHIFT_MODE; // RULE_04 RULE_05
               corner_turn_pkg::COLUMN_SHIFT_MODE: mode_reg <= corner_turn_pkg::ROW_SHIFT_MODE; // RULE_07
               default:                            mode_reg <= corner_turn_pkg::ROW_SHIFT_MODE;
            endcase
         end
      end
   end

   // Two-entry skid buffer: output stage plus one spare word
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_reg        <= corner_turn_pkg::WORD_RESET;
         out_valid_reg  <= 1'b0;
         skid_reg       <= corner_turn_pkg::WORD_RESET;
         skid_valid_reg <= 1'b0;
         in_ready_reg   <= 1'b1;
      end else if (clk_en) begin
         if (out_load) begin
            out_valid_reg <= skid_valid_reg | push;
            out_reg       <= skid_valid_reg ? skid_reg : leaving;
         end
         if (push && !out_load) begin
            skid_reg <= leaving;
         end
         skid_valid_reg <= skid_valid_next;
         in_ready_reg   <= ~skid_valid_next;
      end
   end

   assign in_ready    = in_ready_reg;
   assign right_bits  = right_column(cell_reg); // RULE_10
   assign bottom_bits = cell_reg[corner_turn_pkg::ARRAY_DIM-1]; // RULE_10
   assign mode        = mode_reg;
   assign out_word    = out_reg;
   assign out_valid   = out_valid_reg;

   // Checks
   sequence s_row_start;
      advance && mode_reg == corner_turn_pkg::ROW_SHIFT_MODE &&
      cnt_reg == corner_turn_pkg::CNT_RESET;
   endsequence

   sequence s_col_start;
      advance && mode_reg == corner_turn_pkg::COLUMN_SHIFT_MODE &&
      cnt_reg == corner_turn_pkg::CNT_RESET;
   endsequence

   sequence s_seven_more;
      advance [*7];
   endsequence

   a_row_neighbour: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_02
      advance && mode_reg == corner_turn_pkg::ROW_SHIFT_MODE |=>
         cell_reg[2][5] == $past(cell_reg[2][4]) && cell_reg[4][0] == $past(din[4]))
      else $error("row shift did not take the left neighbour");

   a_col_neighbour: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_03
      advance && mode_reg == corner_turn_pkg::COLUMN_SHIFT_MODE |=>
         cell_reg[5][3] == $past(cell_reg[4][3]) && cell_reg[0][6] == $past(din[6]))
      else $error("column shift did not take the cell above");

   a_serial_through: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_04
      s_row_start ##1 s_seven_more |=>
         cell_reg[0][7] == $past(din[0], 8) &&
         mode_reg == corner_turn_pkg::COLUMN_SHIFT_MODE)
      else $error("serial bit did not reach the right column after eight row steps");

   a_word_through: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_05
      s_col_start ##1 s_seven_more |=>
         cell_reg[7] == $past(din, 8) && mode_reg == corner_turn_pkg::ROW_SHIFT_MODE)
      else $error("parallel word did not reach the bottom row after eight column steps");

   a_mode_period: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_08
      $changed(mode_reg) |-> $past(cnt_reg) == corner_turn_pkg::CNT_LAST && $past(advance))
      else $error("mode changed away from a counter wrap");

   a_stall_freeze: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_06
      !advance |=> $stable(cell_reg) && $stable(cnt_reg) && $stable(mode_reg))
      else $error("array moved without a step");

   a_start_row: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_11
      !primed_reg |-> mode_reg == corner_turn_pkg::ROW_SHIFT_MODE)
      else $error("first block not in row shift mode");

   a_out_hold: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_06
      out_valid_reg && !out_ready |=> out_valid_reg && $stable(out_reg))
      else $error("stalled output word changed");

   a_no_loss: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_06
      clk_en && push && !out_load |=> skid_valid_reg && skid_reg == $past(leaving))
      else $error("word lost while receiver stalled");

   // Single steps in each mode, reused by the edge checks below
   sequence s_row_step;
      advance && mode_reg == corner_turn_pkg::ROW_SHIFT_MODE;
   endsequence

   sequence s_col_step;
      advance && mode_reg == corner_turn_pkg::COLUMN_SHIFT_MODE;
   endsequence

   // Edge and corner cells catch an index slip that interior cells would hide
   a_row_far: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_02
      s_row_step |=>
         cell_reg[7][7] == $past(cell_reg[7][6]) &&
         cell_reg[0][1] == $past(cell_reg[0][0]) &&
         cell_reg[3][0] == $past(din[3]))
      else $error("row shift lost a corner cell");

   a_col_far: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_03
      s_col_step |=>
         cell_reg[7][0] == $past(cell_reg[6][0]) &&
         cell_reg[1][7] == $past(cell_reg[0][7]))
      else $error("column shift lost a corner cell");

   a_col_entry: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_09
      s_col_step |=>
         cell_reg[0] == $past(din))
      else $error("parallel word did not enter the top row");

   a_count_step: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_08
      advance |=>
         cnt_reg == $past(cnt_reg) + corner_turn_pkg::CNT_ONE)
      else $error("phase counter did not advance by one");

   a_mode_hold: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_08
      advance && !wrap |=>
         $stable(mode_reg))
      else $error("mode changed inside a phase");

   a_wrap_toggle: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_07
      wrap |=>
         mode_reg != $past(mode_reg))
      else $error("mode did not flip at the counter wrap");

   a_row_leave: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_07
      push && mode_reg == corner_turn_pkg::ROW_SHIFT_MODE |->
         !leaving.from_bottom &&
         leaving.bits[0] == cell_reg[0][7] &&
         leaving.bits[7] == cell_reg[7][7])
      else $error("row phase word not taken from the right column");

   a_col_leave: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_05
      push && mode_reg == corner_turn_pkg::COLUMN_SHIFT_MODE |->
         leaving.from_bottom &&
         leaving.bits == cell_reg[7])
      else $error("column phase word not taken from the bottom row");

   // The first block after reset only fills the array
   a_prime_after: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_11
      (!primed_reg && advance && cnt_reg == corner_turn_pkg::CNT_RESET) ##1 s_seven_more |=>
         primed_reg &&
         mode_reg == corner_turn_pkg::COLUMN_SHIFT_MODE)
      else $error("array not primed after the first eight steps");

   a_quiet_start: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_11
      !primed_reg |->
         !out_valid_reg && !skid_valid_reg)
      else $error("reset contents offered as data");

   a_skid_blocks: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_06
      skid_valid_reg |->
         !in_ready_reg && !advance)
      else $error("input accepted while the spare slot was full");

   a_skid_drain: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_06
      clk_en && out_ready && skid_valid_reg |=>
         out_valid_reg && !skid_valid_reg &&
         out_reg == $past(skid_reg))
      else $error("spare word not moved to the output");

   a_push_direct: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_06
      clk_en && push && !out_valid_reg |=>
         out_valid_reg &&
         out_reg == $past(leaving))
      else $error("leaving word not presented at the output");

   a_taken_clears: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_06
      clk_en && out_valid_reg && out_ready && !skid_valid_reg && !push |=>
         !out_valid_reg)
      else $error("taken word offered twice");

   a_ready_back: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_06
      clk_en && !skid_valid_next |=>
         in_ready_reg)
      else $error("input stayed refused with the spare slot free");

   // Clock enable low must hold the buffer as well as the array
   a_enable_freeze: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_06
      !clk_en |=>
         $stable(out_reg) && $stable(out_valid_reg) &&
         $stable(skid_valid_reg) && $stable(in_ready_reg))
      else $error("buffer moved with the clock enable low");

   a_mode_output: assert property (@(posedge sys_clk) disable iff (!reset_n) // RULE_04
      !primed_reg && advance && cnt_reg != corner_turn_pkg::CNT_LAST |=>
         mode_reg == corner_turn_pkg::ROW_SHIFT_MODE)
      else $error("first block left row shift mode early");

endmodule : corner_turn

// ===== common/corner_turn_pkg.sv
// Constants, mode encoding and carrier types for the 8x8 corner-turn converter
package corner_turn_pkg;

   // Array geometry: rows equal columns equal word width
   localparam int ARRAY_DIM   = 8;
   localparam int CNT_W       = 3;
   // Divide-by-eight phase counter
   localparam logic [CNT_W-1:0] CNT_RESET = 3'h0;
   localparam logic [CNT_W-1:0] CNT_LAST  = 3'h7;
   localparam logic [CNT_W-1:0] CNT_ONE   = 3'h1;
   // Cell reset value, one row at a time
   localparam logic [ARRAY_DIM-1:0] ROW_RESET = 8'h00;
   // Field positions inside the outgoing word
   localparam int WORD_BITS_LSB = 0;
   localparam int WORD_SRC_POS  = ARRAY_DIM;

   typedef enum logic {
      ROW_SHIFT_MODE    = 1'b0,
      COLUMN_SHIFT_MODE = 1'b1
   } mode_t;

   typedef logic [ARRAY_DIM-1:0]                 row_t;
   typedef logic [ARRAY_DIM-1:0][ARRAY_DIM-1:0]  cells_t;

   // One word leaving the array; from_bottom set when it left the bottom row
   typedef struct packed {
      logic                 from_bottom;
      logic [ARRAY_DIM-1:0] bits;
   } word_t;

   localparam word_t WORD_RESET = '{from_bottom: 1'b0, bits: 8'h00};

endpackage : corner_turn_pkg

// ===== verif/pcm_sink.sv
// Word consumer on the far side of the merged output, able to stall
`timescale 1ns/100ps

module pcm_sink (
   // Clock
   input  wire logic sys_clk,
   // Stall request from the bench
   input  wire logic stall,
   // Merged word stream handshake
   output      logic out_ready
);
   // Registered on the rising edge so bench and sink never race on stall
   initial out_ready = 1'b0;
   always @(posedge sys_clk) begin
      out_ready <= ~stall;
   end
endmodule : pcm_sink

// ===== verif/corner_turn_tb.sv
// Self-checking bench for the corner-turn converter
`timescale 1ns/100ps

module corner_turn_tb;
   logic                   sys_clk, reset_n, clk_en, in_valid, in_ready;
   logic                   out_valid, out_ready, stall;
   logic [7:0]             din, right_bits, bottom_bits, rcol;
   corner_turn_pkg::mode_t mode;
   corner_turn_pkg::word_t out_word;
   logic [7:0]             cells [8];
   logic [8:0]             exp_q [$];
   int                     steps, err_total, n_compared;

   corner_turn corner_turn_i (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
      .din(din), .in_valid(in_valid), .in_ready(in_ready), .right_bits(right_bits),
      .bottom_bits(bottom_bits), .mode(mode), .out_word(out_word),
      .out_valid(out_valid), .out_ready(out_ready));
   pcm_sink pcm_sink_i (.sys_clk(sys_clk), .stall(stall), .out_ready(out_ready));

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [8:0] seen, input logic [8:0] want);
      n_compared++;
      if (seen !== want) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic summarize();
      if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : summarize

   // Reference array: column 0 left, row 0 top; words leave before the shift
   always @(posedge sys_clk) begin
      for (int r = 0; r < 8; r++) rcol[r] = cells[r][7];
      if (reset_n && clk_en && out_valid && out_ready)
         check(out_word, exp_q.size() ? exp_q.pop_front() : 9'bx);
      if (reset_n && clk_en && in_valid && in_ready) begin
         if (steps[3] == 1'b0) begin
            if (steps >= 8) exp_q.push_back({1'b0, rcol});
            for (int r = 0; r < 8; r++) cells[r] = {cells[r][6:0], din[r]};
         end else begin
            exp_q.push_back({1'b1, cells[7]});
            for (int r = 7; r > 0; r--) cells[r] = cells[r-1];
            cells[0] = din;
         end
         steps++;
      end
   end

   task automatic do_reset();
      @(negedge sys_clk);
      reset_n = 1'b0;
      steps = 0;
      exp_q.delete();
      for (int r = 0; r < 8; r++) cells[r] = 8'h00;
      repeat (5) @(negedge sys_clk);
      reset_n = 1'b1;
      check(9'({in_ready, out_valid, mode}), 9'h004);
   endtask : do_reset

   // Source offers a word or bit slice every cycle, held until taken
   task automatic run(input int n, input logic stl);
      logic [7:0] rc;
      repeat (n) begin
         @(negedge sys_clk);
         for (int r = 0; r < 8; r++) rc[r] = cells[r][7];
         check(9'(mode), 9'(steps[3]));
         check(9'(right_bits), 9'(rc));
         check(9'(bottom_bits), 9'(cells[7]));
         stall = stl;
         in_valid = 1'b1;
         din = 8'(steps * 37 + 8'h5a);
      end
   endtask : run

   task automatic drain();
      @(negedge sys_clk);
      in_valid = 1'b0;
      stall = 1'b0;
      for (int i = 0; i < 40 && (exp_q.size() != 0 || out_valid !== 1'b0); i++)
         @(negedge sys_clk);
      check(9'(exp_q.size()), 9'h000);
   endtask : drain

   task automatic t_stream();
      run(40, 1'b0);
      drain();
   endtask : t_stream

   // Two-entry buffer must refuse rather than lose words
   task automatic t_stall();
      run(12, 1'b1);
      check(9'(in_ready), 9'h000);
      run(20, 1'b0);
      drain();
   endtask : t_stall

   task automatic t_freeze();
      run(3, 1'b0);
      clk_en = 1'b0;
      run(6, 1'b0);
      clk_en = 1'b1;
      run(10, 1'b0);
      drain();
   endtask : t_freeze

   initial begin
      {reset_n, clk_en, in_valid, stall, din} = {1'b0, 1'b1, 1'b0, 1'b0, 8'h00};
      {err_total, n_compared, steps} = 0;
      do_reset();
      t_stream();
      t_stall();
      t_freeze();
      run(5, 1'b0);
      do_reset();
      t_stream();
      summarize();
   end

   initial begin
      #(50 * 2000);
      err_total++;
      summarize();
   end
endmodule : corner_turn_tb
